//--- hw/smh_bus_if.sv
// Host parallel bus between the shared-memory device and its host master.
// The shared data lines are resolved here from the two output enables.
`timescale 1ns/1ns
interface smh_bus_if;
  import smh_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic cs_n;
  logic rd_n;
  logic write_strobe_upper_n;
  logic write_strobe_lower_n;
  logic [DATA_W-1:0] host_dout;
  logic host_doe;
  logic [DATA_W-1:0] dev_dout;
  logic dev_doe;
  wire [DATA_W-1:0] data_bus;

  assign data_bus = host_doe ? host_dout : (dev_doe ? dev_dout : 16'h0000);

  modport dev (
    input addr,
    input cs_n,
    input rd_n,
    input write_strobe_upper_n,
    input write_strobe_lower_n,
    input data_bus,
    output dev_dout,
    output dev_doe
  );
  modport host (
    output addr,
    output cs_n,
    output rd_n,
    output write_strobe_upper_n,
    output write_strobe_lower_n,
    output host_dout,
    output host_doe,
    input data_bus
  );
endinterface

//--- hw/smh_device.sv
// Shared network memory with read snapshot and write staging channels, host bus slave side.
// Assumes the host changes bus signals right after a rising clk edge and keeps strobes one cycle.
// Function
// - Control 0 write copies block into buffer 0.
// - Host snapshots first, then reads the buffer.
// - Second independent read snapshot channel.
// - Host fills whole staging buffer before commit.
// - Commit 0 write stores staging buffer 0 atomically.
// - Second independent write staging channel.
// - Host writes full words, both strobes low.
// - One global memory, no window locking.
// - Utility select picks hi-z, cycle or ping.
// - Pulses leave only via the two utility pins.
// - Transmit data held low during reset.
// - System supplies a ready clock, no oscillator.
// - Commit 0 at 33C, commit 1 next word.
// - Snapshot buffer 0 spans bytes 370 to 377.
`timescale 1ns/1ns
module smh_device
  import smh_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  smh_bus_if.dev bus,
  input wire logic net_we,
  input wire logic [smh_pkg::BLK_W-1:0] net_wr_blk,
  input wire logic [smh_pkg::BLOCK_W-1:0] net_wr_data,
  input wire logic [smh_pkg::BLK_W-1:0] net_rd_blk,
  output logic [smh_pkg::BLOCK_W-1:0] net_rd_data,
  input wire logic cycle_timing_pulse_n,
  input wire logic ping_pulse_n,
  input wire logic tx_data_in,
  output logic txd,
  output logic aux_output_pin_a_out,
  output logic aux_output_pin_a_oe,
  output logic aux_output_pin_b_out,
  output logic aux_output_pin_b_oe
);
  import smh_pkg::*;

  // One flat memory with no window locking; consistency comes only from the buffers.
  // The array has no reset, so a block reads as unknown until the network or the host writes it.
  logic [BLOCK_W-1:0] global_shared_memory [NUM_BLOCKS];
  logic [BLOCK_W-1:0] read_snapshot_buf_reg [NUM_CH];
  logic [BLOCK_W-1:0] write_staging_buf_reg [NUM_CH];
  logic [BLK_W-1:0] read_snapshot_ctrl_reg [NUM_CH];
  logic [BLK_W-1:0] write_commit_ctrl_reg [NUM_CH];
  logic [DATA_W-1:0] utility_pin_select_reg;
  logic [DATA_W-1:0] dout_reg;
  logic [DATA_W-1:0] dout_next;
  logic doe_reg;
  logic [BLOCK_W-1:0] net_rd_reg;
  logic txd_reg;
  logic pin_a_reg;
  logic pin_b_reg;
  logic pin_a_oe_reg;
  logic pin_b_oe_reg;

  // Address bit 0 is dropped: every register and memory word is one whole 16-bit location.
  wire [ADDR_W-1:0] waddr = {bus.addr[ADDR_W-1:1], 1'b0};
  wire sel = !bus.cs_n;
  // A write counts only with both byte strobes low; a lone byte strobe is ignored.
  wire wr = sel && !bus.write_strobe_upper_n && !bus.write_strobe_lower_n;
  wire rd = sel && !bus.rd_n && bus.write_strobe_upper_n && bus.write_strobe_lower_n;
  wire [DATA_W-1:0] wdata = bus.data_bus;
  wire [BLK_W-1:0] tgt_blk = wdata[BLK_W-1:0];
  wire mem_hit = waddr < SHARED_MEM_LIMIT;
  wire [BLK_W-1:0] mem_blk = waddr[BLK_W+2:3];
  wire [1:0] word_idx = waddr[2:1];
  // Control pairs sit two bytes apart and buffer pairs eight, so each kind has its own channel bit.
  wire ch = waddr[1];
  wire buf_ch = waddr[3];
  wire rctl_hit = waddr == READ_SNAPSHOT_CTRL_0 || waddr == READ_SNAPSHOT_CTRL_1;
  wire wctl_hit = waddr == WRITE_COMMIT_CTRL_0 || waddr == WRITE_COMMIT_CTRL_1;
  wire util_hit = waddr == UTILITY_PIN_SELECT;
  wire rbuf_hit = waddr[ADDR_W-1:4] == READ_SNAPSHOT_BUF_0[ADDR_W-1:4];
  wire wbuf_hit = waddr[ADDR_W-1:4] == WRITE_STAGING_BUF_0[ADDR_W-1:4];
  wire mem_wr = wr && mem_hit;
  wire snap_wr = wr && rctl_hit;
  wire commit_wr = wr && wctl_hit;
  wire [1:0] sel_a = utility_pin_select_reg[UTIL_A_LSB +: UTIL_SEL_W];
  wire [1:0] sel_b = utility_pin_select_reg[UTIL_B_LSB +: UTIL_SEL_W];

  // Read sources, one word each, chosen by the address decoder below.
  wire [DATA_W-1:0] mem_word = smh_word(global_shared_memory[mem_blk], word_idx);
  wire [DATA_W-1:0] rctl_word = {10'h000, read_snapshot_ctrl_reg[ch]};
  wire [DATA_W-1:0] wctl_word = {10'h000, write_commit_ctrl_reg[ch]};
  wire [DATA_W-1:0] rbuf_word = smh_word(read_snapshot_buf_reg[buf_ch], word_idx);
  wire [DATA_W-1:0] wbuf_word = smh_word(write_staging_buf_reg[buf_ch], word_idx);

  // A pin that is not driving still shows the idle high level, so enabling it later cannot glitch low.
  function automatic logic pin_level(input logic [1:0] s, input logic cyc_n, input logic png_n);
    pin_level = (s == SMH_PIN_CYCLE) ? cyc_n : ((s == SMH_PIN_PING) ? png_n : 1'b1);
  endfunction

  function automatic logic pin_drive(input logic [1:0] s);
    pin_drive = (s == SMH_PIN_CYCLE) || (s == SMH_PIN_PING);
  endfunction

  // Read data is registered, so the answer stands only in the cycle after the read strobe.
  always_comb
  begin
    dout_next = 16'h0000;
    if (mem_hit)
      dout_next = mem_word;
    else if (rctl_hit)
      dout_next = rctl_word;
    else if (wctl_hit)
      dout_next = wctl_word;
    else if (util_hit)
      dout_next = utility_pin_select_reg;
    else if (rbuf_hit)
      dout_next = rbuf_word;
    else if (wbuf_hit)
      dout_next = wbuf_word;
  end

  // Network writes land first so a host commit to the same block in the same cycle wins whole.
  always_ff @(posedge clk)
  begin
    if (net_we)
      global_shared_memory[net_wr_blk] <= net_wr_data;
    if (mem_wr)
      global_shared_memory[mem_blk][word_idx*DATA_W +: DATA_W] <= wdata;
    if (commit_wr)
      global_shared_memory[tgt_blk] <= write_staging_buf_reg[ch];
  end

  // The snapshot samples the memory before this edge's updates, so it is never a mix.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        read_snapshot_buf_reg[i] <= 64'h0000000000000000;
        write_staging_buf_reg[i] <= 64'h0000000000000000;
        read_snapshot_ctrl_reg[i] <= 6'h00;
        write_commit_ctrl_reg[i] <= 6'h00;
      end
    end
    else
    begin
      if (snap_wr)
      begin
        read_snapshot_ctrl_reg[ch] <= tgt_blk;
        read_snapshot_buf_reg[ch] <= global_shared_memory[tgt_blk];
      end
      if (commit_wr)
        write_commit_ctrl_reg[ch] <= tgt_blk;
      // Host writes to the snapshot buffers are dropped; those buffers change only by a snapshot.
      if (wr && wbuf_hit)
        write_staging_buf_reg[buf_ch][word_idx*DATA_W +: DATA_W] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      utility_pin_select_reg <= UTIL_RESET;
      dout_reg <= 16'h0000;
      doe_reg <= 1'b0;
      net_rd_reg <= 64'h0000000000000000;
    end
    else
    begin
      if (wr && util_hit)
        utility_pin_select_reg <= wdata;
      dout_reg <= dout_next;
      doe_reg <= rd;
      net_rd_reg <= global_shared_memory[net_rd_blk];
    end
  end

  // Registered pin stage; during reset the transmit line is a steady low, not a divided clock.
  // Output enables lag the select by one cycle, exactly as the pin levels do.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      txd_reg <= 1'b0;
      pin_a_reg <= 1'b1;
      pin_b_reg <= 1'b1;
      pin_a_oe_reg <= 1'b0;
      pin_b_oe_reg <= 1'b0;
    end
    else
    begin
      txd_reg <= tx_data_in;
      pin_a_reg <= pin_level(sel_a, cycle_timing_pulse_n, ping_pulse_n);
      pin_b_reg <= pin_level(sel_b, cycle_timing_pulse_n, ping_pulse_n);
      pin_a_oe_reg <= pin_drive(sel_a);
      pin_b_oe_reg <= pin_drive(sel_b);
    end
  end

  assign bus.dev_dout = dout_reg;
  assign bus.dev_doe = doe_reg;
  assign net_rd_data = net_rd_reg;
  assign txd = txd_reg;
  assign aux_output_pin_a_out = pin_a_reg;
  assign aux_output_pin_a_oe = pin_a_oe_reg;
  assign aux_output_pin_b_out = pin_b_reg;
  assign aux_output_pin_b_oe = pin_b_oe_reg;
endmodule

//--- hw/smh_host.sv
// Host bus master for the shared-memory device: single accesses and hazard-free block transfers.
// Assumes the device answers a read strobe with data in the next cycle and never stalls.
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ns
module smh_host
  import smh_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  smh_bus_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_op,
  input wire logic cmd_write,
  input wire logic cmd_ch,
  input wire logic [smh_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [smh_pkg::BLOCK_W-1:0] cmd_wdata,
  output logic rsp_valid,
  output logic [smh_pkg::BLOCK_W-1:0] rsp_data
);
  import smh_pkg::*;

  typedef enum logic [2:0] {SMH_IDLE, SMH_SINGLE, SMH_CAPTURE, SMH_STAGE, SMH_COMMIT, SMH_TRIGGER,
    SMH_READ, SMH_DONE} smh_state_e;

  smh_state_e state_reg;
  smh_state_e state_next;
  logic [1:0] idx_reg;
  logic [1:0] op_reg;
  logic write_reg;
  logic ch_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [BLOCK_W-1:0] data_reg;
  logic reading_reg;

  wire [ADDR_W-1:0] rbuf_base = ch_reg ? READ_SNAPSHOT_BUF_1 : READ_SNAPSHOT_BUF_0;
  wire [ADDR_W-1:0] wbuf_base = ch_reg ? WRITE_STAGING_BUF_1 : WRITE_STAGING_BUF_0;
  wire [ADDR_W-1:0] word_off = {7'h00, idx_reg, 1'b0};
  wire [BLK_W-1:0] blk = addr_reg[BLK_W+2:3];
  wire take = cmd_valid && state_reg == SMH_IDLE;
  wire last = idx_reg == 2'h3;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      SMH_IDLE:
        if (cmd_valid)
          state_next = (cmd_op == HOST_OP_BLOCK_READ) ? SMH_TRIGGER :
                       (cmd_op == HOST_OP_BLOCK_WRITE) ? SMH_STAGE : SMH_SINGLE;
      SMH_SINGLE:
        state_next = write_reg ? SMH_DONE : SMH_CAPTURE;
      SMH_CAPTURE:
        state_next = SMH_DONE;
      SMH_STAGE:
        state_next = last ? SMH_COMMIT : SMH_STAGE;
      SMH_COMMIT:
        state_next = SMH_DONE;
      SMH_TRIGGER:
        state_next = SMH_READ;
      SMH_READ:
        state_next = last ? SMH_CAPTURE : SMH_READ;
      SMH_DONE:
        state_next = SMH_IDLE;
      default:
        state_next = SMH_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= SMH_IDLE;
      idx_reg <= 2'h0;
      op_reg <= HOST_OP_SINGLE;
      write_reg <= 1'b0;
      ch_reg <= 1'b0;
      addr_reg <= 10'h000;
      data_reg <= 64'h0000000000000000;
      reading_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      reading_reg <= (state_reg == SMH_SINGLE && !write_reg) || state_reg == SMH_READ;
      if (take)
      begin
        op_reg <= cmd_op;
        write_reg <= cmd_write;
        ch_reg <= cmd_ch;
        addr_reg <= cmd_addr;
        data_reg <= cmd_wdata;
        idx_reg <= 2'h0;
      end
      else if (state_reg == SMH_STAGE || state_reg == SMH_READ)
        idx_reg <= idx_reg + 2'h1;
      // Read words arrive one cycle behind their strobe and shift into the block from the top.
      if (reading_reg)
      begin
        if (op_reg == HOST_OP_BLOCK_READ)
          data_reg <= {bus.data_bus, data_reg[BLOCK_W-1:DATA_W]};
        else
          data_reg <= {48'h000000000000, bus.data_bus};
      end
    end
  end

  // The whole block is staged before the commit strobe, never part of it.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bus.addr <= 10'h000;
      bus.cs_n <= 1'b1;
      bus.rd_n <= 1'b1;
      bus.write_strobe_upper_n <= 1'b1;
      bus.write_strobe_lower_n <= 1'b1;
      bus.host_dout <= 16'h0000;
      bus.host_doe <= 1'b0;
    end
    else
    begin
      bus.cs_n <= 1'b1;
      bus.rd_n <= 1'b1;
      bus.write_strobe_upper_n <= 1'b1;
      bus.write_strobe_lower_n <= 1'b1;
      bus.host_doe <= 1'b0;
      case (state_next)
        SMH_SINGLE:
        begin
          bus.addr <= take ? cmd_addr : addr_reg;
          bus.cs_n <= 1'b0;
          bus.rd_n <= cmd_write;
          bus.write_strobe_upper_n <= !cmd_write;
          bus.write_strobe_lower_n <= !cmd_write;
          bus.host_dout <= cmd_wdata[DATA_W-1:0];
          bus.host_doe <= cmd_write;
        end
        SMH_STAGE, SMH_COMMIT:
        begin
          bus.cs_n <= 1'b0;
          bus.write_strobe_upper_n <= 1'b0;
          bus.write_strobe_lower_n <= 1'b0;
          bus.host_doe <= 1'b1;
          if (state_next == SMH_COMMIT)
          begin
            bus.addr <= ch_reg ? WRITE_COMMIT_CTRL_1 : WRITE_COMMIT_CTRL_0;
            bus.host_dout <= {10'h000, blk};
          end
          else
          begin
            bus.addr <= (take ? (cmd_ch ? WRITE_STAGING_BUF_1 : WRITE_STAGING_BUF_0) : wbuf_base) +
              (take ? 10'h000 : word_off + 10'h002);
            bus.host_dout <= take ? cmd_wdata[DATA_W-1:0] : smh_word(data_reg, idx_reg + 2'h1);
          end
        end
        SMH_TRIGGER:
        begin
          bus.addr <= cmd_ch ? READ_SNAPSHOT_CTRL_1 : READ_SNAPSHOT_CTRL_0;
          bus.cs_n <= 1'b0;
          bus.write_strobe_upper_n <= 1'b0;
          bus.write_strobe_lower_n <= 1'b0;
          bus.host_dout <= {10'h000, cmd_addr[BLK_W+2:3]};
          bus.host_doe <= 1'b1;
        end
        SMH_READ:
        begin
          bus.addr <= rbuf_base + ((state_reg == SMH_TRIGGER) ? 10'h000 : word_off + 10'h002);
          bus.cs_n <= 1'b0;
          bus.rd_n <= 1'b0;
        end
        default:
        begin
          bus.addr <= bus.addr;
        end
      endcase
    end
  end

  assign cmd_ready = state_reg == SMH_IDLE;
  assign rsp_valid = state_reg == SMH_DONE;
  assign rsp_data = data_reg;
endmodule

//--- hw/smh_pkg.sv
// Constants shared by the shared-memory hazard-buffer device and its host bus master.
// Assumes a 16-bit host bus with byte addressing and one common clock.
package smh_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam int BLK_W = 6;
  localparam int NUM_BLOCKS = 64;
  localparam int BLOCK_W = 64;
  localparam int WORDS_PER_BLOCK = 4;
  localparam int NUM_CH = 2;
  localparam int CLK_PERIOD_NS = 100;
  localparam logic [ADDR_W-1:0] SHARED_MEM_LIMIT = 10'h200;
  localparam logic [ADDR_W-1:0] READ_SNAPSHOT_CTRL_0 = 10'h338;
  localparam logic [ADDR_W-1:0] READ_SNAPSHOT_CTRL_1 = 10'h33A;
  localparam logic [ADDR_W-1:0] WRITE_COMMIT_CTRL_0 = 10'h33C;
  localparam logic [ADDR_W-1:0] WRITE_COMMIT_CTRL_1 = 10'h33E;
  localparam logic [ADDR_W-1:0] UTILITY_PIN_SELECT = 10'h34E;
  localparam logic [ADDR_W-1:0] READ_SNAPSHOT_BUF_0 = 10'h370;
  localparam logic [ADDR_W-1:0] READ_SNAPSHOT_BUF_1 = 10'h378;
  localparam logic [ADDR_W-1:0] WRITE_STAGING_BUF_0 = 10'h380;
  localparam logic [ADDR_W-1:0] WRITE_STAGING_BUF_1 = 10'h388;
  localparam int UTIL_A_LSB = 0;
  localparam int UTIL_B_LSB = 2;
  localparam int UTIL_SEL_W = 2;
  localparam logic [DATA_W-1:0] UTIL_RESET = 16'h0000;
  typedef enum logic [1:0] {SMH_PIN_HIZ, SMH_PIN_CYCLE, SMH_PIN_PING, SMH_PIN_OFF} smh_pin_sel_e;
  localparam logic [1:0] HOST_OP_SINGLE = 2'h0;
  localparam logic [1:0] HOST_OP_BLOCK_READ = 2'h1;
  localparam logic [1:0] HOST_OP_BLOCK_WRITE = 2'h2;

  // Word idx of a 64-bit block, lowest byte address holding bits 15:0.
  function automatic logic [DATA_W-1:0] smh_word(input logic [BLOCK_W-1:0] blk, input logic [1:0] idx);
    smh_word = blk[idx*DATA_W +: DATA_W];
  endfunction
endpackage

//--- verification/shared_memory_hazard_buffers_test.sv
// Self-checking bench: host master and device joined on one bus, driven through the host commands.
// Assumes a 10 MHz clock and exactly one response pulse per command.
`timescale 1ns/1ns
module shared_memory_hazard_buffers_test;
  import smh_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, net_we = 1'b0, cycle_timing_pulse_n = 1'b1, ping_pulse_n = 1'b1;
  logic tx_data_in = 1'b1, txd, a_out, a_oe, b_out, b_oe, cmd_valid = 1'b0, cmd_ready, cmd_write = 1'b0;
  logic cmd_ch = 1'b0, rsp_valid;
  logic [5:0] net_wr_blk = 6'h00, net_rd_blk = 6'h00;
  logic [1:0] cmd_op = 2'h0;
  logic [9:0] cmd_addr = 10'h000;
  logic [63:0] net_wr_data = 64'h0, cmd_wdata = 64'h0, net_rd_data, rsp_data, exp_q[$], mask_q[$], mem[64];
  logic [31:0] seed = 32'h72B2;
  int failures = 0, tests_run = 0, rsp_cnt = 0;
  always #50 clk = ~clk;
  smh_bus_if bus ();
  smh_device smh_device_i (.clk(clk), .nrst(nrst), .bus(bus.dev), .net_we(net_we), .net_wr_blk(net_wr_blk),
    .net_wr_data(net_wr_data), .net_rd_blk(net_rd_blk), .net_rd_data(net_rd_data),
    .cycle_timing_pulse_n(cycle_timing_pulse_n), .ping_pulse_n(ping_pulse_n), .tx_data_in(tx_data_in),
    .txd(txd), .aux_output_pin_a_out(a_out), .aux_output_pin_a_oe(a_oe), .aux_output_pin_b_out(b_out),
    .aux_output_pin_b_oe(b_oe));
  smh_host smh_host_i (.clk(clk), .nrst(nrst), .bus(bus.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_write(cmd_write), .cmd_ch(cmd_ch), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  smh_props smh_props_i (.clk(clk), .nrst(nrst), .addr(bus.addr), .cs_n(bus.cs_n), .rd_n(bus.rd_n),
    .write_strobe_upper_n(bus.write_strobe_upper_n), .write_strobe_lower_n(bus.write_strobe_lower_n),
    .host_doe(bus.host_doe), .dev_doe(bus.dev_doe), .txd(txd), .aux_output_pin_a_oe(a_oe),
    .aux_output_pin_b_oe(b_oe));

  task automatic print_verdict();
    if (failures == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [63:0] rnd();
    logic [63:0] v;
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    v[31:0] = seed;
    repeat (7) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    v[63:32] = seed;
    return v;
  endfunction

  // The expectation is noted before the command starts, so the monitor never races the driver.
  task automatic cmd(input logic [1:0] op, input logic w, input logic ch, input logic [9:0] a,
    input logic [63:0] wd, input logic [63:0] m, input logic [63:0] e);
    int n;
    n = rsp_cnt + 1;
    exp_q.push_back(e);
    mask_q.push_back(m);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_write <= w;
    cmd_ch <= ch;
    cmd_addr <= a;
    cmd_wdata <= wd;
    @(posedge clk);
    cmd_valid <= 1'b0;
    for (int i = 0; i < 20 && rsp_cnt != n; i++)
      @(posedge clk);
    if (rsp_cnt != n)
    begin
      failures++;
      print_verdict();
    end
  endtask

  task automatic pin_check(input logic [1:0] sel, input logic o, input logic oe, input logic [1:0] d);
    logic e_oe;
    e_oe = (sel == SMH_PIN_CYCLE) || (sel == SMH_PIN_PING);
    check({62'h0, oe, o}, {62'h0, e_oe, e_oe ? ((sel == SMH_PIN_CYCLE) ? d[0] : d[1]) : 1'b1});
  endtask

  always @(posedge clk)
  begin
    if (nrst && rsp_valid === 1'b1)
    begin
      check(rsp_data & mask_q.pop_front(), exp_q.pop_front());
      rsp_cnt++;
    end
  end

  initial
  begin
    logic [63:0] d;
    logic [5:0] b;
    repeat (8) @(posedge clk);
    check({63'h0, txd}, 64'h0);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      d = rnd();
      b = (i == 0) ? 6'h00 : ((i == 1) ? 6'h3F : d[37:32]);
      mem[b] = d;
      cmd(HOST_OP_BLOCK_WRITE, 1'b0, i[0], {1'b0, b, 3'h0}, d, 64'h0, 64'h0);
      net_rd_blk <= b;
      repeat (2) @(posedge clk);
      check(net_rd_data, d);
      cmd(HOST_OP_BLOCK_READ, 1'b0, ~i[0], {1'b0, b, 3'h0}, 64'h0, '1, d);
    end
    for (int k = 0; k < 4; k++)
      cmd(HOST_OP_SINGLE, 1'b0, 1'b0, {1'b0, b, 3'h0} + 10'(2 * k), 64'h0, 64'hFFFF, 64'(mem[b][16*k +: 16]));
    d = rnd();
    @(posedge clk);
    net_we <= 1'b1;
    net_wr_blk <= b;
    net_wr_data <= d;
    @(posedge clk);
    net_we <= 1'b0;
    for (int c = 0; c < 2; c++)
      cmd(HOST_OP_BLOCK_READ, 1'b0, c[0], {1'b0, b, 3'h0}, 64'h0, '1, d);
    cmd(HOST_OP_SINGLE, 1'b0, 1'b0, 10'h3A0, 64'h0, 64'hFFFF, 64'h0);
    cmd(HOST_OP_SINGLE, 1'b1, 1'b0, {1'b0, b, 3'h2}, 64'hA5C3, 64'h0, 64'h0);
    d[31:16] = 16'hA5C3;
    cmd(HOST_OP_BLOCK_READ, 1'b0, 1'b1, {1'b0, b, 3'h0}, 64'h0, '1, d);
    cmd(HOST_OP_SINGLE, 1'b0, 1'b0, READ_SNAPSHOT_CTRL_1, 64'h0, 64'hFFFF, 64'(b));
    cmd(HOST_OP_SINGLE, 1'b0, 1'b0, WRITE_COMMIT_CTRL_1, 64'h0, 64'hFFFF, 64'(b));
    cmd(HOST_OP_SINGLE, 1'b0, 1'b0, WRITE_STAGING_BUF_1 + 10'h006, 64'h0, 64'hFFFF, 64'(mem[b][63:48]));
    for (int s = 0; s < 16; s++)
    begin
      d = rnd();
      cycle_timing_pulse_n <= d[0];
      ping_pulse_n <= d[1];
      tx_data_in <= d[2];
      cmd(HOST_OP_SINGLE, 1'b1, 1'b0, UTILITY_PIN_SELECT, 64'(s), 64'h0, 64'h0);
      repeat (2) @(posedge clk);
      pin_check(2'(s), a_out, a_oe, d[1:0]);
      pin_check(2'(s >> 2), b_out, b_oe, d[1:0]);
      check({63'h0, txd}, {63'h0, d[2]});
    end
    tx_data_in <= 1'b1;
    cmd(HOST_OP_SINGLE, 1'b1, 1'b0, UTILITY_PIN_SELECT, 64'h0009, 64'h0, 64'h0);
    repeat (2) @(posedge clk);
    check({62'h0, a_oe, b_oe}, 64'h3);
    check({63'h0, txd}, 64'h1);
    // A reset in mid-run must pull the transmit line low and release both utility pins.
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    check({63'h0, txd}, 64'h0);
    check({62'h0, a_oe, b_oe}, 64'h0);
    nrst <= 1'b1;
    cmd(HOST_OP_SINGLE, 1'b0, 1'b0, UTILITY_PIN_SELECT, 64'h0, 64'hFFFF, 64'(UTIL_RESET));
    print_verdict();
  end
endmodule

//--- verification/smh_props.sv
// Checker for the host bus that joins the device and its master, plus a few device pins.
// Assumes the bench wires every input by name and that only the master issues bus cycles.
`timescale 1ns/1ns
module smh_props
  import smh_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [smh_pkg::ADDR_W-1:0] addr,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic write_strobe_upper_n,
  input wire logic write_strobe_lower_n,
  input wire logic host_doe,
  input wire logic dev_doe,
  input wire logic txd,
  input wire logic aux_output_pin_a_oe,
  input wire logic aux_output_pin_b_oe
);
  import smh_pkg::*;
  // The first edge in reset only loads the reset values, so the reset checks start one edge later.
  logic rst_seen = 1'b0;
  always @(posedge clk)
    rst_seen <= 1'b1;
  wire wr = !cs_n && !write_strobe_upper_n && !write_strobe_lower_n;
  wire rd = !cs_n && !rd_n && write_strobe_upper_n;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_wr_at(logic [ADDR_W-1:0] a);
    wr && addr == a;
  endsequence
  sequence s_rd_at(logic [ADDR_W-1:0] a);
    rd && addr == a ##1 dev_doe;
  endsequence
  property p_full_word;
    write_strobe_upper_n == write_strobe_lower_n;
  endproperty
  a_full_word: assert property (p_full_word) else $error("byte strobes split");
  property p_no_rd_wr;
    !(!rd_n && !write_strobe_lower_n);
  endproperty
  a_no_rd_wr: assert property (p_no_rd_wr) else $error("read and write together");
  property p_read_answer;
    rd |=> dev_doe;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_doe_cause;
    dev_doe |-> $past(rd);
  endproperty
  a_doe_cause: assert property (p_doe_cause) else $error("device drove without read");
  property p_no_clash;
    !(host_doe && dev_doe);
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("both drive data");
  property p_commit0;
    s_wr_at(WRITE_STAGING_BUF_0 + 10'h006) |=> s_wr_at(WRITE_COMMIT_CTRL_0);
  endproperty
  a_commit0: assert property (p_commit0) else $error("commit 0 not after fill");
  property p_commit1;
    s_wr_at(WRITE_STAGING_BUF_1 + 10'h006) |=> s_wr_at(WRITE_COMMIT_CTRL_1);
  endproperty
  a_commit1: assert property (p_commit1) else $error("commit 1 not after fill");
  property p_snap0;
    s_wr_at(READ_SNAPSHOT_CTRL_0) |=> s_rd_at(READ_SNAPSHOT_BUF_0);
  endproperty
  a_snap0: assert property (p_snap0) else $error("snapshot 0 not read back");
  property p_snap1;
    s_wr_at(READ_SNAPSHOT_CTRL_1) |=> s_rd_at(READ_SNAPSHOT_BUF_1);
  endproperty
  a_snap1: assert property (p_snap1) else $error("snapshot 1 not read back");
  // Reset behaviour is watched while reset is active, so these two ignore the default disable.
  property p_txd_reset;
    disable iff (1'b0) !nrst && rst_seen |-> !txd;
  endproperty
  a_txd_reset: assert property (p_txd_reset) else $error("transmit line moved in reset");
  property p_aux_reset;
    disable iff (1'b0) !nrst && rst_seen |-> !aux_output_pin_a_oe && !aux_output_pin_b_oe;
  endproperty
  a_aux_reset: assert property (p_aux_reset) else $error("utility pin driven in reset");
endmodule
